// file: cgc_gate_ctrl.sv
// Purpose: Gate control for a 16-bit counter, with Avalon-MM registers
// Assumes: Pin and overflow gate inputs and count_tick synchronous to mclk, 20 MHz
// Notes:   Every access gets one wait cycle; count_advance is registered
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`include "cgc_params.svh"
module cgc_gate_ctrl (
   input  wire cgc_pkg::cgc_avmm_req_t avs_req,
   input  wire logic                   mclk,
   input  wire logic                   arst_n,
   output      logic [`CGC_DW-1:0]     avs_readdata,
   output      logic                   avs_waitrequest,
   input  wire cgc_pkg::cgc_gate_in_t  gate_in,
   input  wire logic                   count_tick,
   output      logic                   count_advance,
   output      logic                   irq
);
   import cgc_pkg::*;

   cgc_top_st_t st_reg;
   cgc_top_st_t st_next;
   logic        cmp_sync;
   logic        gate_src;
   logic        gate_shaped;
   logic        gate_rise;
   logic        gate_fall;
   logic        gate_final;
   logic        acc;
   logic        wr;
   logic        sp_done;

   // Comparator may be asynchronous, so it gets its own synchroniser
   cgc_sync u_cmp_sync (
      .mclk   (mclk),
      .arst_n (arst_n),
      .d      (gate_in.cmp),
      .q      (cmp_sync)
   );

   // Gate source select; the reserved code yields a low source
   always_comb begin
      unique case (st_reg.ctrl.src_sel)
         `CGC_SRC_PIN: gate_src = gate_in.pin;
         `CGC_SRC_TMR: gate_src = gate_in.ovf;
         `CGC_SRC_CMP: begin
            gate_src = st_reg.cfg.cmp_sync_en ? cmp_sync
                                              : gate_in.cmp;
         end
         default:      gate_src = 1'b0;
      endcase
   end

   cgc_gate_shaper u_shaper (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .gate_src  (gate_src),
      .gate_pol  (st_reg.ctrl.gate_pol),
      .gate_tog  (st_reg.ctrl.gate_tog),
      .gate_out  (gate_shaped),
      .gate_rise (gate_rise),
      .gate_fall (gate_fall)
   );

   // In single-pulse mode only the one captured pulse opens the gate
   assign gate_final = gate_shaped & (~st_reg.ctrl.gate_sp
                     | st_reg.sp_active
                     | (st_reg.ctrl.acq_go & gate_rise));

   // Bus handshake: one wait cycle so read data come from a flop
   assign acc             = avs_req.read | avs_req.write;
   assign wr              = avs_req.write & st_reg.ack;
   assign avs_waitrequest = acc & ~st_reg.ack;
   assign avs_readdata    = st_reg.rdata;
   assign count_advance   = st_reg.advance;
   assign irq             = |(st_reg.ist & st_reg.imsk);

   // Next state: acquisition, register writes, read capture, counting
   always_comb begin
      cgc_ctrl_t wctl;
      cgc_ctrl_t rctl;
      cgc_irq_t  w1c;
      wctl    = cgc_ctrl_t'(avs_req.writedata[`CGC_CTRL_W-1:0]);
      rctl    = st_reg.ctrl;
      w1c     = '0;
      st_next = st_reg;
      sp_done = 1'b0;
      st_next.ack = acc & ~st_reg.ack;

      // Single-pulse acquisition
      if (st_reg.ctrl.acq_go && gate_rise) begin
         st_next.sp_active = 1'b1;
      end
      if (st_reg.sp_active && gate_fall) begin
         st_next.sp_active    = 1'b0;
         st_next.ctrl.acq_go  = 1'b0;
         sp_done              = 1'b1;
      end

      // Register writes; a software arm beats the hardware clear
      if (wr) begin
         unique case (avs_req.address)
            `CGC_OFS_CTRL: begin
               st_next.ctrl          = wctl;
               st_next.ctrl.gate_val = 1'b0;
               if (!wctl.acq_go) begin
                  st_next.sp_active = 1'b0;
               end
               if (wctl.acq_go) begin
                  st_next.ctrl.acq_go = 1'b1;
                  st_next.sp_active   = 1'b0;
               end
            end
            `CGC_OFS_CFG: begin
               st_next.cfg      = cgc_cfg_t'(avs_req.writedata[7:0]);
               st_next.cfg.rsvd = '0;
            end
            `CGC_OFS_IST:  w1c = cgc_irq_t'(avs_req.writedata[1:0]);
            `CGC_OFS_IMSK: st_next.imsk = cgc_irq_t'(avs_req.writedata[1:0]);
            default: ;
         endcase
      end

      // Mode off: nothing armed, nothing in progress
      if (!st_next.ctrl.gate_sp) begin
         st_next.ctrl.acq_go = 1'b0;
         st_next.sp_active   = 1'b0;
      end

      // Sticky events, set wins over a same-cycle clear
      st_next.ist.acq_done  = (st_reg.ist.acq_done & ~w1c.acq_done)
                              | sp_done;
      st_next.ist.gate_rise = (st_reg.ist.gate_rise & ~w1c.gate_rise)
                              | gate_rise;

      // Read capture in the wait cycle; gate value is live
      rctl.gate_val = gate_final;
      if (avs_req.read && !st_reg.ack) begin
         unique case (avs_req.address)
            `CGC_OFS_CTRL: st_next.rdata = {24'h000000, rctl};
            `CGC_OFS_CFG:  st_next.rdata = {24'h000000, st_reg.cfg};
            `CGC_OFS_IST:  st_next.rdata = {30'h0, st_reg.ist};
            `CGC_OFS_IMSK: st_next.rdata = {30'h0, st_reg.imsk};
            default:       st_next.rdata = '0;
         endcase
      end

      // Counting permission
      st_next.advance = count_tick & st_reg.cfg.counter_on
                        & (~st_reg.ctrl.gate_en | gate_final);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence sp_armed_edge;
      st_reg.ctrl.gate_sp && st_reg.ctrl.acq_go && gate_rise && !wr;
   endsequence

   sequence sp_pulse_end;
      st_reg.sp_active && gate_fall && !wr;
   endsequence

   count_gated_a: assert property (count_tick && st_reg.cfg.counter_on && st_reg.ctrl.gate_en && !gate_final |=> !count_advance)
      else $error("counter advanced with gate closed");
   count_off_a: assert property (!st_reg.cfg.counter_on |=> !count_advance)
      else $error("counter advanced while switched off");
   count_free_a: assert property (count_tick && st_reg.cfg.counter_on && !st_reg.ctrl.gate_en |=> count_advance)
      else $error("ungated count event was dropped");
   sp_capture_a: assert property (sp_armed_edge |=> st_reg.sp_active ##0 st_reg.ctrl.acq_go)
      else $error("armed edge did not start the pulse");
   sp_wait_a: assert property (st_reg.ctrl.gate_sp && st_reg.ctrl.acq_go && !st_reg.sp_active && !wr |=> st_reg.ctrl.acq_go)
      else $error("status dropped while waiting for edge");
   sp_done_a: assert property (sp_pulse_end |=> !st_reg.ctrl.acq_go ##0 st_reg.ist.acq_done)
      else $error("status not cleared at pulse end");
   sp_idle_a: assert property (!st_reg.ctrl.gate_sp && !wr |=> !st_reg.ctrl.acq_go && !st_reg.sp_active)
      else $error("single-pulse logic active while mode off");
   gate_read_a: assert property (
      avs_req.read && !st_reg.ack && avs_req.address == `CGC_OFS_CTRL
      |=> avs_readdata[3:0] == {$past(st_reg.ctrl.acq_go), $past(gate_final),
                                $past(st_reg.ctrl.src_sel)})
      else $error("gate value readback wrong");
   src_tmr_a: assert property (st_reg.ctrl.src_sel == `CGC_SRC_TMR |-> gate_src == gate_in.ovf)
      else $error("companion overflow not selected");
   src_cmp_a: assert property (st_reg.ctrl.src_sel == `CGC_SRC_CMP && st_reg.cfg.cmp_sync_en |-> gate_src == cmp_sync)
      else $error("synchronised comparator not selected");
   src_pin_a: assert property (st_reg.ctrl.src_sel == `CGC_SRC_PIN |-> gate_src == gate_in.pin)
      else $error("gate pin not selected");
   src_rsv_a: assert property (st_reg.ctrl.src_sel == `CGC_SRC_RSV |-> !gate_src)
      else $error("reserved source not idle");
   bus_answer_a: assert property (acc |-> ##[0:1] !avs_waitrequest)
      else $error("bus access not answered in one cycle");

endmodule

// file: cgc_params.svh
// Purpose: Constants for the counter gate control block
// Assumes: Included by the package, cgc_gate_ctrl and the bench
// Notes:   Bus offsets are byte addresses on a 32-bit Avalon-MM slave
// Operation
// - Counter on and gate enabled: counting only while gate function allows.
// - Counter on and gate enable clear: every count event advances regardless of gate.
// - Polarity one: gate active high, counting while gate high.
// - Polarity zero: gate active low, counting while gate low.
// - Toggle mode on: gate flip-flop flips on each gate rising edge.
// - Toggle mode off: toggle stage bypassed and flip-flop held clear.
// - Single-pulse bit set routes gate through acquisition; clear makes it idle.
// - Acquisition status reads one while armed and waiting for gate edge.
// - Acquisition status reads zero when finished or never started.
// - Gate value bit shows gate state that would reach the counter.
// - Source code 10 picks comparator output, optionally synchronized.
// - Source code 01 picks companion timer overflow output.
// - Gate value readback ignores the gate enable bit.
`ifndef CGC_PARAMS_SVH
`define CGC_PARAMS_SVH

`define CGC_DW       32
`define CGC_AW       4
`define CGC_CTRL_W   8
`define CGC_OFS_CTRL 4'h0
`define CGC_OFS_CFG  4'h4
`define CGC_OFS_IST  4'h8
`define CGC_OFS_IMSK 4'hC
`define CGC_SRC_PIN  2'h0
`define CGC_SRC_TMR  2'h1
`define CGC_SRC_CMP  2'h2
`define CGC_SRC_RSV  2'h3

`endif

// file: cgc_pkg.sv
// Purpose: Types shared by the counter gate control modules
// Assumes: cgc_params.svh supplies the widths
// Notes:   Control struct order matches the register bit order 7..0
`include "cgc_params.svh"
package cgc_pkg;

   typedef struct packed {
      logic       gate_en;
      logic       gate_pol;
      logic       gate_tog;
      logic       gate_sp;
      logic       acq_go;
      logic       gate_val;
      logic [1:0] src_sel;
   } cgc_ctrl_t;

   typedef struct packed {
      logic [5:0] rsvd;
      logic       cmp_sync_en;
      logic       counter_on;
   } cgc_cfg_t;

   typedef struct packed {
      logic gate_rise;
      logic acq_done;
   } cgc_irq_t;

   typedef struct packed {
      logic                read;
      logic                write;
      logic [`CGC_AW-1:0]  address;
      logic [`CGC_DW-1:0]  writedata;
   } cgc_avmm_req_t;

   typedef struct packed {
      logic pin;
      logic cmp;
      logic ovf;
   } cgc_gate_in_t;

   typedef struct packed {
      logic meta;
      logic sync;
   } cgc_sync_st_t;

   typedef struct packed {
      logic pol_prev;
      logic toggle;
      logic out_prev;
   } cgc_shp_st_t;

   typedef struct packed {
      cgc_ctrl_t          ctrl;
      cgc_cfg_t           cfg;
      cgc_irq_t           ist;
      cgc_irq_t           imsk;
      logic               ack;
      logic [`CGC_DW-1:0] rdata;
      logic               sp_active;
      logic               advance;
   } cgc_top_st_t;

endpackage

// file: cgc_sync.sv
// Purpose: Two-stage synchroniser for the comparator gate source
// Assumes: Input may change at any time relative to mclk
// Notes:   Only the second stage leaves this module
`timescale 1ns/100ps
module cgc_sync (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic d,
   output      logic q
);
   import cgc_pkg::*;

   cgc_sync_st_t st_reg;
   cgc_sync_st_t st_next;

   // First stage feeds the second and nothing else
   always_comb begin
      st_next      = st_reg;
      st_next.meta = d;
      st_next.sync = st_reg.meta;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.sync;

endmodule

// file: cgc_gate_shaper.sv
// Purpose: Gate polarity and toggle stage, with edge detection
// Assumes: Selected gate source is synchronous to mclk
// Notes:   Toggle output lags the polarised gate by one cycle
`timescale 1ns/100ps
module cgc_gate_shaper (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic gate_src,
   input  wire logic gate_pol,
   input  wire logic gate_tog,
   output      logic gate_out,
   output      logic gate_rise,
   output      logic gate_fall
);
   import cgc_pkg::*;

   cgc_shp_st_t st_reg;
   cgc_shp_st_t st_next;
   logic        pol_gate;

   // Polarity, toggle flip-flop and output edges
   always_comb begin
      st_next          = st_reg;
      pol_gate         = gate_pol ? gate_src : ~gate_src;
      st_next.pol_prev = pol_gate;
      if (gate_tog) begin
         if (pol_gate && !st_reg.pol_prev) begin
            st_next.toggle = ~st_reg.toggle;
         end
      end else begin
         st_next.toggle = 1'b0;
      end
      gate_out         = gate_tog ? st_reg.toggle : pol_gate;
      st_next.out_prev = gate_out;
      gate_rise        = gate_out & ~st_reg.out_prev;
      gate_fall        = ~gate_out & st_reg.out_prev;
   end

   // Edge memory starts at the open level of the reset-state gate
   // (active low, source low), so no false rise follows reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '{pol_prev: 1'b1, toggle: 1'b0, out_prev: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   pol_high_a: assert property (gate_pol && !gate_tog |-> gate_out == gate_src)
      else $error("active-high gate not passed through");
   pol_low_a: assert property (!gate_pol && !gate_tog |-> gate_out != gate_src)
      else $error("active-low gate not inverted");
   toggle_flip_a: assert property (gate_tog && pol_gate && !st_reg.pol_prev |=> gate_out != $past(gate_out))
      else $error("toggle stage missed a rising edge");
   toggle_clear_a: assert property (!gate_tog |=> !st_reg.toggle)
      else $error("toggle flip-flop not held clear");

endmodule

// file: cgc_src_model.sv
// Purpose: Model of the gate sources beside the gated counter
// Assumes: Pin, comparator and companion timer levels set by the bench
// Notes:   Levels pass one flop, like the clocked logic that makes them
`timescale 1ns/100ps
module cgc_src_model (
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   input  wire logic                  pin_lvl,
   input  wire logic                  cmp_lvl,
   input  wire logic                  ovf_lvl,
   output      cgc_pkg::cgc_gate_in_t gate_in
);
   import cgc_pkg::*;

   // Registered source levels, all low in reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         gate_in <= '0;
      end else begin
         gate_in <= '{pin: pin_lvl, cmp: cmp_lvl, ovf: ovf_lvl};
      end
   end
endmodule

// file: cgc_gate_ctrl_tb.sv
// Purpose: Self-checking bench for the counter gate control block
// Assumes: Source model gives gate levels synchronous to mclk
// Notes:   Read data and count results are checked against queued notes
`timescale 1ns/100ps
`include "cgc_params.svh"
module cgc_gate_ctrl_tb;
   import cgc_pkg::*;
   cgc_avmm_req_t      avs_req;
   logic               mclk;
   logic               arst_n;
   logic [`CGC_DW-1:0] avs_readdata;
   logic               avs_waitrequest;
   cgc_gate_in_t       gate_in;
   logic               count_tick;
   logic               count_advance;
   logic               irq;
   logic               pin_lvl;
   logic               cmp_lvl;
   logic               ovf_lvl;
   logic               tick_d;
   logic [31:0]        rd_q[$];
   logic               adv_q[$];
   int                 failures;
   int                 n_checks;
   int                 i;
   logic [1:0]         src;
   logic               pol;
   logic               lvl;
   logic               ge;
   logic               gv;

   cgc_gate_ctrl dut (.avs_req(avs_req), .mclk(mclk), .arst_n(arst_n),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .gate_in(gate_in), .count_tick(count_tick),
      .count_advance(count_advance), .irq(irq));

   cgc_src_model far (.mclk(mclk), .arst_n(arst_n), .pin_lvl(pin_lvl),
      .cmp_lvl(cmp_lvl), .ovf_lvl(ovf_lvl), .gate_in(gate_in));

   // 20 MHz clock
   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      // Notes never answered count as mismatches
      if (rd_q.size() + adv_q.size() > 0) begin
         failures++;
         $display("BAD %0t unanswered notes", $time);
      end
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One bus cycle; held until waitrequest is seen low, then released
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int k;
      avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
      k = 0;
      // Waitrequest sampled at each rising edge until seen low
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      if (avs_waitrequest !== 1'b0) begin
         failures++;
         final_report();
      end
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   // Count events back to back, each with its expected advance
   task automatic ticks(input int n, input logic e);
      repeat (n) begin
         count_tick <= 1'b1;
         adv_q.push_back(e);
         @(posedge mclk);
      end
      count_tick <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   // Source levels; six cycles cover the model flop and the synchroniser
   task automatic lv(input logic p, input logic c, input logic o);
      pin_lvl <= p;
      cmp_lvl <= c;
      ovf_lvl <= o;
      repeat (6) @(posedge mclk);
   endtask

   // Level output is looked at mid-cycle, away from the edge
   task automatic irq_is(input logic e);
      @(negedge mclk);
      check({31'h0, irq}, {31'h0, e});
      @(posedge mclk);
   endtask

   // Result watcher: read data and count advances against oldest notes
   always @(negedge mclk) begin
      if (avs_req.read && avs_waitrequest === 1'b0 && rd_q.size() > 0)
         check(avs_readdata, rd_q.pop_front());
      if (tick_d && adv_q.size() > 0)
         check({31'h0, count_advance}, {31'h0, adv_q.pop_front()});
      tick_d = count_tick;
   end

   // Watchdog; a hang counts as a mismatch
   initial begin
      #500000;
      failures++;
      final_report();
   end

   initial begin
      avs_req = '0;
      arst_n = 1'b0;
      count_tick = 1'b0;
      pin_lvl = 1'b0;
      cmp_lvl = 1'b0;
      ovf_lvl = 1'b0;
      tick_d = 1'b0;
      failures = 0;
      n_checks = 0;
      i = $urandom(53520);
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      // Reset state; low-active gate with pin low reads open
      irq_is(1'b0);
      rd(`CGC_OFS_CTRL, 32'h04);
      rd(`CGC_OFS_CFG, 32'h0);
      rd(`CGC_OFS_IMSK, 32'h0);
      rd(4'h2, 32'h0);
      // Count path with gate enable off, on, and counter off
      wr(`CGC_OFS_CFG, 32'h3);
      wr(`CGC_OFS_CTRL, 32'h40);
      ticks(4, 1'b1);
      wr(`CGC_OFS_CTRL, 32'hC0);
      ticks(4, 1'b0);
      lv(1'b1, 1'b0, 1'b0);
      ticks(4, 1'b1);
      wr(`CGC_OFS_CTRL, 32'h80);
      ticks(3, 1'b0);
      wr(`CGC_OFS_CFG, 32'h2);
      ticks(3, 1'b0);
      wr(`CGC_OFS_CFG, 32'h3);
      // Every source code and polarity, the other sources opposite
      for (i = 0; i < 16; i++) begin
         src = i[1:0];
         pol = i[2];
         lvl = i[3];
         ge = 1'($urandom);
         // Reserved code feeds a low source; polarity still applies
         gv = (src == 2'h3) ? !pol : (pol ? lvl : !lvl);
         lv(src == 2'h0 ? lvl : !lvl, src == 2'h2 ? lvl : !lvl,
            src == 2'h1 ? lvl : !lvl);
         wr(`CGC_OFS_CTRL, {24'h0, ge, pol, 3'b000, 1'($urandom), src});
         rd(`CGC_OFS_CTRL, {24'h0, ge, pol, 3'b000, gv, src});
         ticks(2, ge ? gv : 1'b1);
      end
      // Toggle stage flips per rising edge and clears when off
      lv(1'b0, 1'b0, 1'b0);
      wr(`CGC_OFS_CTRL, 32'h60);
      rd(`CGC_OFS_CTRL, 32'h60);
      lv(1'b1, 1'b0, 1'b0);
      lv(1'b0, 1'b0, 1'b0);
      rd(`CGC_OFS_CTRL, 32'h64);
      lv(1'b1, 1'b0, 1'b0);
      lv(1'b0, 1'b0, 1'b0);
      rd(`CGC_OFS_CTRL, 32'h60);
      lv(1'b1, 1'b0, 1'b0);
      lv(1'b0, 1'b0, 1'b0);
      wr(`CGC_OFS_CTRL, 32'h40);
      rd(`CGC_OFS_CTRL, 32'h40);
      wr(`CGC_OFS_CTRL, 32'h60);
      rd(`CGC_OFS_CTRL, 32'h60);
      // Single pulse: armed, one gated pulse, done, interrupt
      wr(`CGC_OFS_IST, 32'h3);
      wr(`CGC_OFS_IMSK, 32'h1);
      wr(`CGC_OFS_CTRL, 32'hD8);
      rd(`CGC_OFS_CTRL, 32'hD8);
      irq_is(1'b0);
      ticks(2, 1'b0);
      lv(1'b1, 1'b0, 1'b0);
      ticks(2, 1'b1);
      lv(1'b0, 1'b0, 1'b0);
      rd(`CGC_OFS_CTRL, 32'hD0);
      rd(`CGC_OFS_IST, 32'h3);
      irq_is(1'b1);
      wr(`CGC_OFS_IST, 32'h1);
      irq_is(1'b0);
      // Without re-arming, a second pulse stays shut out
      lv(1'b1, 1'b0, 1'b0);
      ticks(2, 1'b0);
      lv(1'b0, 1'b0, 1'b0);
      wr(`CGC_OFS_IMSK, 32'h2);
      irq_is(1'b1);
      wr(`CGC_OFS_IST, 32'h3);
      irq_is(1'b0);
      repeat (4) @(posedge mclk);
      final_report();
   end
endmodule
